// *** rtl/fall_trig_pkg.sv ***
// Package: register map, field layout and reset values of the falling-edge trigger block
`default_nettype none
package fall_trig_pkg;
   localparam int          NUM_PINS         = 16;
   localparam logic [11:0] OFF_TRIG_SET     = 12'h000;
   localparam logic [11:0] OFF_TRIG_CLEAR   = 12'h004;
   localparam logic [11:0] OFF_IRQ_STATUS   = 12'h008;
   localparam logic [11:0] OFF_IRQ_MASK     = 12'h00C;
   localparam logic [11:0] OFF_PIN_LEVEL    = 12'h010;
   localparam int          FIELD_LSB        = 0;
   localparam int          FIELD_MSB        = 15;
   localparam logic [15:0] RST_ENABLE_VEC   = 16'h0000;
   localparam logic [15:0] RST_IRQ_MASK     = 16'h0000;
   localparam logic [15:0] RST_IRQ_STATUS   = 16'h0000;
   localparam logic [31:0] RST_RDATA        = 32'h0000_0000;
   localparam int          SYNC_STAGES      = 2;

   // Places a pin-wide field in the low bits of a bus word, upper bits zero
   function automatic logic [31:0] to_word(input logic [15:0] v);
      return {16'h0000, v};
   endfunction
endpackage
`default_nettype wire

// *** rtl/fall_edge_detect.sv ***
// Per-pin synchroniser and falling-edge detector
`default_nettype none
module fall_edge_detect #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Pins and results
   input  wire logic [WIDTH-1:0] pin_async,
   output logic      [WIDTH-1:0] pin_level,
   output logic      [WIDTH-1:0] fall_seen
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] prev_q;

   // Pin count must fit the low half of a bus word
   if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
      $error("WIDTH out of range");
   end

   // ==========================================
   // Synchroniser: meta_q is read only by sync_q
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= pin_async;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign pin_level = sync_q;
   assign fall_seen = prev_q & ~sync_q;

   property p_fall_def;
      @(posedge pclk) disable iff (!presetn)
      fall_seen == ($past(sync_q) & ~sync_q);
   endproperty
   a_fall_def: assert property (p_fall_def) else $error("fall_seen not prev high, now low");
endmodule // fall_edge_detect
`default_nettype wire

// *** rtl/fall_trig_ctrl.sv ***
// Falling-edge trigger control: APB registers, edge events and interrupt
`default_nettype none
// Operation
// - Enabled pin with a falling edge raises its interrupt event.
// - Enable vector has no address; only set and clear registers change it.
// - Writing 1 to clear register bit 15-0 clears that enable bit.
// - Zero bits written to clear register leave enable bits unchanged.
// - Reading clear register returns the enable vector in bits 15-0.
// - Clear register bits 31-16 read zero; writes to them ignored.
// - Writing 1 to set register bit sets enable bit; zeros no effect.
module fall_trig_ctrl #(
   parameter int NPINS = fall_trig_pkg::NUM_PINS
) (
   // Clock and reset
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   // APB slave
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [11:0]                   paddr,
   input  wire logic [31:0]                   pwdata,
   output logic                               pready,
   output logic                               pslverr,
   output logic      [31:0]                   prdata,
   // Pins and events
   input  wire logic [fall_trig_pkg::NUM_PINS-1:0] general_pin,
   output logic      [fall_trig_pkg::NUM_PINS-1:0] pin_interrupt_event,
   output logic                               irq
);
   import fall_trig_pkg::*;

   logic [NUM_PINS-1:0] falling_trigger_enable_vector_q;
   logic [NUM_PINS-1:0] irq_status_q;
   logic [NUM_PINS-1:0] irq_mask_q;
   logic [NUM_PINS-1:0] event_q;
   logic [NUM_PINS-1:0] pin_level;
   logic [NUM_PINS-1:0] fall_seen;
   logic [NUM_PINS-1:0] event_d;
   logic [NUM_PINS-1:0] wfield;
   logic                wr_en;
   logic                rd_en;
   logic                hit;

   // Register fields are laid out for exactly NUM_PINS pins
   if (NPINS != NUM_PINS) begin : g_bad_npins
      $error("NPINS must equal NUM_PINS");
   end

   // ==========================================
   // Edge detection
   fall_edge_detect #(.WIDTH(NUM_PINS)) u_edge (
      .pclk      (pclk),
      .presetn   (presetn),
      .pin_async (general_pin),
      .pin_level (pin_level),
      .fall_seen (fall_seen)
   );

   // ==========================================
   // APB decode; zero wait states so every access ends in one access cycle
   assign pready  = 1'b1;
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & ~penable & ~pwrite;
   assign wfield  = pwdata[FIELD_MSB:FIELD_LSB];
   always_comb begin
      case (paddr)
         OFF_TRIG_SET, OFF_TRIG_CLEAR, OFF_IRQ_STATUS, OFF_IRQ_MASK, OFF_PIN_LEVEL: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   // Unmapped addresses answer with an error and read zero
   assign pslverr = psel & penable & ~hit;

   // ==========================================
   // Enable vector: reachable only through set and clear, set wins a tie
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         falling_trigger_enable_vector_q <= RST_ENABLE_VEC;
      end else if (wr_en && paddr == OFF_TRIG_SET) begin
         falling_trigger_enable_vector_q <= falling_trigger_enable_vector_q | wfield;
      end else if (wr_en && paddr == OFF_TRIG_CLEAR) begin
         falling_trigger_enable_vector_q <= falling_trigger_enable_vector_q & ~wfield;
      end
   end

   // ==========================================
   // Per-pin event pulse, one cycle per qualified edge
   assign event_d = fall_seen & falling_trigger_enable_vector_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_q <= '0;
      end else begin
         event_q <= event_d;
      end
   end
   assign pin_interrupt_event = event_q;

   // ==========================================
   // Interrupt status (write one to clear, a new event beats the clear) and mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_q <= RST_IRQ_STATUS;
      end else if (wr_en && paddr == OFF_IRQ_STATUS) begin
         irq_status_q <= (irq_status_q & ~wfield) | event_q;
      end else begin
         irq_status_q <= irq_status_q | event_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_q <= RST_IRQ_MASK;
      end else if (wr_en && paddr == OFF_IRQ_MASK) begin
         irq_mask_q <= wfield;
      end
   end

   assign irq = |(irq_status_q & irq_mask_q);

   // ==========================================
   // Read data captured in the setup cycle, held through the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= RST_RDATA;
      end else if (rd_en) begin
         case (paddr)
            OFF_TRIG_SET:   prdata <= to_word(falling_trigger_enable_vector_q);
            OFF_TRIG_CLEAR: prdata <= to_word(falling_trigger_enable_vector_q);
            OFF_IRQ_STATUS: prdata <= to_word(irq_status_q);
            OFF_IRQ_MASK:   prdata <= to_word(irq_mask_q);
            OFF_PIN_LEVEL:  prdata <= to_word(pin_level);
            default:        prdata <= RST_RDATA;
         endcase
      end
   end

   // ==========================================
   // Checks
   property p_event_cause;
      @(posedge pclk) disable iff (!presetn)
      pin_interrupt_event == ($past(fall_seen) & $past(falling_trigger_enable_vector_q));
   endproperty
   a_event_cause: assert property (p_event_cause) else $error("event without enabled edge");

   property p_vec_stable;
      @(posedge pclk) disable iff (!presetn)
      !(wr_en && (paddr == OFF_TRIG_SET || paddr == OFF_TRIG_CLEAR))
         |=> $stable(falling_trigger_enable_vector_q);
   endproperty
   a_vec_stable: assert property (p_vec_stable) else $error("enable vector changed without access");

   property p_clear_ones;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == OFF_TRIG_CLEAR) |=> ((falling_trigger_enable_vector_q & $past(wfield)) == '0);
   endproperty
   a_clear_ones: assert property (p_clear_ones) else $error("clear left bit set");

   property p_clear_zeros;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == OFF_TRIG_CLEAR) |=>
         ((falling_trigger_enable_vector_q & ~$past(wfield)) == ($past(falling_trigger_enable_vector_q) & ~$past(wfield)));
   endproperty
   a_clear_zeros: assert property (p_clear_zeros) else $error("clear disturbed zero bits");

   property p_read_clear;
      @(posedge pclk) disable iff (!presetn)
      (rd_en && paddr == OFF_TRIG_CLEAR) ##1 (psel && penable)
         |-> prdata[15:0] == $past(falling_trigger_enable_vector_q);
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("clear register read wrong");

   property p_reserved_zero;
      @(posedge pclk) disable iff (!presetn)
      prdata[31:16] == 16'h0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

   property p_set_ones;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == OFF_TRIG_SET) |=>
         (falling_trigger_enable_vector_q == ($past(falling_trigger_enable_vector_q) | $past(wfield)));
   endproperty
   a_set_ones: assert property (p_set_ones) else $error("set register write wrong");

   property p_fall_to_event;
      @(posedge pclk) disable iff (!presetn)
      (fall_seen[0] && falling_trigger_enable_vector_q[0]) |=> pin_interrupt_event[0] ##1 !pin_interrupt_event[0];
   endproperty
   a_fall_to_event: assert property (p_fall_to_event) else $error("pin 0 event not one cycle");

   property p_read_set;
      @(posedge pclk) disable iff (!presetn)
      (rd_en && paddr == OFF_TRIG_SET) ##1 (psel && penable)
         |-> prdata[15:0] == $past(falling_trigger_enable_vector_q);
   endproperty
   a_read_set: assert property (p_read_set) else $error("set register read wrong");

   property p_unmapped_ignored;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && !hit) |=> ($stable(falling_trigger_enable_vector_q) && $stable(irq_mask_q));
   endproperty
   a_unmapped_ignored: assert property (p_unmapped_ignored) else $error("unmapped write changed state");

   property p_status_set_wins;
      @(posedge pclk) disable iff (!presetn)
      (|event_q) |=> ((irq_status_q & $past(event_q)) == $past(event_q));
   endproperty
   a_status_set_wins: assert property (p_status_set_wins) else $error("event not latched in status");

   property p_status_clear;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == OFF_IRQ_STATUS) |=> ((irq_status_q & $past(wfield) & ~$past(event_q)) == '0);
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("status bit not cleared");

   property p_mask_write;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == OFF_IRQ_MASK) |=> (irq_mask_q == $past(wfield));
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask write wrong");
endmodule // fall_trig_ctrl
`default_nettype wire

// *** tb/pin_model.sv ***
// Far-side pin driver that follows a requested pattern after a lag
`default_nettype none
module pin_model (
   // Clock
   input  wire logic        pclk,
   // Request and pins
   input  wire logic [15:0] want,
   input  wire logic [3:0]  lag,
   output logic      [15:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0]  cnt_q   = 4'h0;
   // Idle pins sit at the pull-up level
   logic [15:0] level_q = 16'hFFFF;
   assign pins = level_q;
   // A lag lets slow external edges be tried as well as prompt ones
   always @(posedge pclk) begin
      if (want != level_q && cnt_q >= lag) begin
         level_q <= want;
         cnt_q <= 4'h0;
      end else if (want != level_q) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule // pin_model
`default_nettype wire

// *** tb/tb_gpio_falling_edge_trigger_clear.sv ***
// Self-checking bench of the falling-edge trigger control block
`default_nettype none
module tb_gpio_falling_edge_trigger_clear;
   import fall_trig_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] want = 16'hFFFF, pins, ev, acc;
   logic [3:0]  lag = 4'h0;
   int          miscompares = 0, total_checks = 0, cycles = 0, hits;
   fall_trig_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .general_pin(pins), .pin_interrupt_event(ev), .irq(irq));
   pin_model i_pins (.pclk(pclk), .want(want), .lag(lag), .pins(pins));
   // ====================
   // Clock, timeout, helpers
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         complete_run();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic watch(input int n);
      acc = 0;
      hits = 0;
      repeat (n) begin
         @(negedge pclk);
         acc = acc | ev;
         hits += (ev != 0);
      end
      @(posedge pclk);
   endtask
   // ====================
   // Scenarios
   task automatic t_reset();
      apb(0, OFF_TRIG_CLEAR, 0);
      check(rd, 32'h0);
      check(irq, 0);
   endtask
   task automatic t_regs();
      apb(1, OFF_TRIG_SET, 32'hFFFF_A5A5);
      apb(0, OFF_TRIG_CLEAR, 0);
      check(rd, 32'h0000_A5A5);
      apb(1, OFF_TRIG_CLEAR, 32'hFFFF_0000);
      apb(0, OFF_TRIG_CLEAR, 0);
      check(rd, 32'h0000_A5A5);
      apb(1, OFF_TRIG_CLEAR, 32'h0000_0005);
      apb(0, OFF_TRIG_SET, 0);
      check(rd, 32'h0000_A5A0);
      apb(1, 12'h014, 32'hFFFF_FFFF);
      check(err, 1);
      apb(0, 12'h014, 0);
      check(rd, 32'h0);
      apb(0, OFF_TRIG_CLEAR, 0);
      check(rd, 32'h0000_A5A0);
   endtask
   task automatic t_pins();
      apb(1, OFF_TRIG_CLEAR, 32'h0000_FFFF);
      apb(1, OFF_TRIG_SET, 32'h0000_0001);
      apb(1, OFF_IRQ_MASK, 32'h0000_0003);
      lag <= 4'h3;
      want <= 16'hFFFC;
      watch(14);
      check({acc, 16'(hits)}, {16'h0001, 16'd1});
      check(irq, 1);
      apb(0, OFF_PIN_LEVEL, 0);
      check(rd, 32'h0000_FFFC);
      apb(0, OFF_IRQ_STATUS, 0);
      check(rd, 32'h0000_0001);
      apb(1, OFF_IRQ_STATUS, 32'h0000_0001);
      check(irq, 0);
      want <= 16'hFFFF;
      watch(14);
      check(acc, 16'h0);
      apb(1, OFF_IRQ_MASK, 32'h0);
      want <= 16'hFFFE;
      watch(14);
      check(acc, 16'h0001);
      check(irq, 0);
   endtask
   task automatic complete_run();
      if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_reset();
      t_regs();
      t_pins();
      complete_run();
   end
endmodule // tb_gpio_falling_edge_trigger_clear
`default_nettype wire
